// ==== core_ctrl.sv ====
// Core control: standby entry and exit, break entry and return, opcode subset
`timescale 1ns/10ps
module core_ctrl
    import core_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_mem_rdata,
    input  wire logic        i_int_req,
    input  wire logic        i_ext_int,
    input  wire logic [15:0] i_int_vector,
    input  wire logic        i_brk_req,
    input  wire logic        i_monitor_mode,
    output mem_req_t         o_mem,
    output logic             o_cpu_clk_en,
    output logic             o_int_ack,
    output logic             o_break_active,
    output logic             o_wait_mode,
    output logic             o_stop_mode,
    output ccr_t             o_ccr,
    output logic [15:0]      o_pc,
    output logic [15:0]      o_sp,
    output logic [15:0]      o_hx,
    output logic [7:0]       o_acc
);

    core_state_t  state_q, state_d;
    logic [2:0]   step_q, step_d;
    logic [15:0]  pc_q, pc_d;
    logic [15:0]  sp_q, sp_d;
    logic [15:0]  hx_q, hx_d;
    logic [7:0]   acc_q, acc_d;
    ccr_t         ccr_q, ccr_d;
    logic [7:0]   ir_q, ir_d;
    logic [7:0]   opnd_q, opnd_d;
    logic [15:0]  vec_q, vec_d;
    mem_req_t     mem_q, mem_d;
    logic         clk_en_q, clk_en_d;
    logic         ack_q, ack_d;
    logic         brk_q, brk_d;
    logic         wait_q, wait_d;
    logic         stop_q, stop_d;
    logic         tmr_start;
    logic         tmr_done;
    logic         done;
    logic [15:0]  done_pc;
    logic         go_push;
    logic [15:0]  ret_pc;
    logic         cin;
    logic [8:0]   sum9;
    logic [4:0]   sum5;
    logic [15:0]  target;

    // Byte stacked at a given step: PC low, PC high, X, A, CCR
    function automatic logic [7:0] push_byte(input logic [2:0] s, input logic [15:0] pc,
                                             input logic [7:0] x, input logic [7:0] a, input ccr_t f);
        case (s)
            3'h0:    push_byte = pc[7:0];
            3'h1:    push_byte = pc[15:8];
            3'h2:    push_byte = x;
            3'h3:    push_byte = a;
            default: push_byte = f;
        endcase
    endfunction

    stab_timer u_stab_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (tmr_start),
        .o_done    (tmr_done)
    );

    // Adder shared by the two accumulator sum opcodes
    always_comb begin
        cin  = (ir_q == OP_SUM_WITH_CARRY_IMM) ? ccr_q.c : 1'b0;
        sum9 = {1'b0, acc_q} + {1'b0, i_mem_rdata} + {8'h00, cin};
        sum5 = {1'b0, acc_q[3:0]} + {1'b0, i_mem_rdata[3:0]} + {4'h0, cin};
        target = pc_q + sext8(opnd_q);
    end

    // Next-state logic of the whole core
    always_comb begin
        state_d   = state_q;
        step_d    = step_q;
        pc_d      = pc_q;
        sp_d      = sp_q;
        hx_d      = hx_q;
        acc_d     = acc_q;
        ccr_d     = ccr_q;
        ir_d      = ir_q;
        opnd_d    = opnd_q;
        vec_d     = vec_q;
        mem_d     = mem_q;
        mem_d.we  = 1'b0;
        clk_en_d  = clk_en_q;
        ack_d     = 1'b0;
        brk_d     = brk_q;
        wait_d    = wait_q;
        stop_d    = stop_q;
        tmr_start = 1'b0;
        done      = 1'b0;
        done_pc   = pc_q;
        go_push   = 1'b0;
        ret_pc    = pc_q;
        case (state_q)
            S_VEC: begin
                if (step_q == 3'h0) begin
                    pc_d[15:8] = i_mem_rdata;
                    mem_d.addr = vec_q + 16'h0001;
                    step_d     = 3'h1;
                end else begin
                    pc_d       = {pc_q[15:8], i_mem_rdata};
                    mem_d.addr = {pc_q[15:8], i_mem_rdata};
                    step_d     = 3'h0;
                    state_d    = S_FETCH;
                end
            end
            S_FETCH: begin
                // Break outranks maskable requests; the mask gates only the latter
                if (i_brk_req && !brk_q) begin
                    brk_d   = 1'b1;
                    ir_d    = OP_SOFT_TRAP_OPCODE;
                    vec_d   = i_monitor_mode ? VEC_TRAP_MONITOR : VEC_TRAP_NORMAL;
                    go_push = 1'b1;
                end else if (i_int_req && !ccr_q.i) begin
                    ack_d   = 1'b1;
                    vec_d   = i_int_vector;
                    go_push = 1'b1;
                end else begin
                    ir_d       = i_mem_rdata;
                    pc_d       = pc_q + 16'h0001;
                    mem_d.addr = pc_q + 16'h0001;
                    step_d     = 3'h0;
                    case (i_mem_rdata)
                        OP_SOFT_TRAP_OPCODE: begin
                            vec_d   = VEC_TRAP_NORMAL;
                            ret_pc  = pc_q + 16'h0001;
                            go_push = 1'b1;
                        end
                        OP_RETURN_FROM_TRAP: begin
                            sp_d       = sp_q + 16'h0001;
                            mem_d.addr = sp_q + 16'h0001;
                            state_d    = S_PULL;
                        end
                        OP_IDLE_STANDBY: begin
                            ccr_d.i  = 1'b0;
                            clk_en_d = 1'b0;
                            wait_d   = 1'b1;
                            state_d  = S_STANDBY;
                        end
                        OP_HALT_STANDBY: begin
                            ccr_d.i  = 1'b0;
                            clk_en_d = 1'b0;
                            stop_d   = 1'b1;
                            state_d  = S_STANDBY;
                        end
                        OP_STACK_PTR_SIGNED_IMM_SUM, OP_INDEX_REG_SIGNED_IMM_SUM,
                        OP_SUM_WITH_CARRY_IMM, OP_SUM_IMM, OP_CONJUNCTION_IMM,
                        OP_BRANCH_ON_NO_CARRY, OP_BRANCH_ON_CARRY,
                        OP_BRANCH_NIBBLE_CARRY_CLR, OP_BRANCH_NIBBLE_CARRY_SET,
                        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_GT: begin
                            state_d = S_EXEC;
                        end
                        // Opcodes outside the subset pass as one-cycle no-ops
                        default: state_d = S_FETCH;
                    endcase
                end
            end
            S_EXEC: begin
                if (step_q == 3'h0) begin
                    opnd_d  = i_mem_rdata;
                    pc_d    = pc_q + 16'h0001;
                    done_pc = pc_q + 16'h0001;
                    done    = 1'b1;
                    case (ir_q)
                        OP_STACK_PTR_SIGNED_IMM_SUM: sp_d = sp_q + sext8(i_mem_rdata);
                        OP_INDEX_REG_SIGNED_IMM_SUM: hx_d = hx_q + sext8(i_mem_rdata);
                        OP_SUM_WITH_CARRY_IMM, OP_SUM_IMM: begin
                            acc_d   = sum9[7:0];
                            ccr_d.c = sum9[8];
                            ccr_d.h = sum5[4];
                            ccr_d.n = sum9[7];
                            ccr_d.z = (sum9[7:0] == BYTE_ZERO);
                            ccr_d.v = (acc_q[7] & i_mem_rdata[7] & ~sum9[7]) |
                                      (~acc_q[7] & ~i_mem_rdata[7] & sum9[7]);
                        end
                        OP_CONJUNCTION_IMM: begin
                            acc_d   = acc_q & i_mem_rdata;
                            ccr_d.v = 1'b0;
                            ccr_d.n = acc_q[7] & i_mem_rdata[7];
                            ccr_d.z = ((acc_q & i_mem_rdata) == BYTE_ZERO);
                        end
                        default: begin
                            // Branches spend a third cycle resolving the target
                            done   = 1'b0;
                            step_d = 3'h1;
                        end
                    endcase
                end else begin
                    done    = 1'b1;
                    done_pc = branch_taken(ir_q, ccr_q) ? target : pc_q;
                    step_d  = 3'h0;
                end
            end
            S_PUSH: begin
                sp_d = sp_q - 16'h0001;
                if (step_q != STACK_LAST_STEP) begin
                    mem_d.addr  = sp_q - 16'h0001;
                    mem_d.wdata = push_byte(step_q + 3'h1, pc_q, hx_q[7:0], acc_q, ccr_q);
                    mem_d.we    = 1'b1;
                    step_d      = step_q + 3'h1;
                end else begin
                    // Mask rises only once the flags have been stacked
                    ccr_d.i    = 1'b1;
                    mem_d.addr = vec_q;
                    step_d     = 3'h0;
                    state_d    = S_VEC;
                end
            end
            S_PULL: begin
                case (step_q)
                    3'h0:    ccr_d = ccr_t'(i_mem_rdata | CCR_FIXED_ONES);
                    3'h1:    acc_d = i_mem_rdata;
                    3'h2:    hx_d[7:0] = i_mem_rdata;
                    3'h3:    pc_d[15:8] = i_mem_rdata;
                    default: pc_d = {pc_q[15:8], i_mem_rdata};
                endcase
                if (step_q != STACK_LAST_STEP) begin
                    sp_d       = sp_q + 16'h0001;
                    mem_d.addr = sp_q + 16'h0001;
                    step_d     = step_q + 3'h1;
                end else begin
                    // A request still held keeps the core in break
                    if (brk_q && !i_brk_req) begin
                        brk_d = 1'b0;
                    end
                    step_d  = 3'h0;
                    done    = 1'b1;
                    done_pc = {pc_q[15:8], i_mem_rdata};
                end
            end
            S_STANDBY: begin
                // Mask stays clear across a wake by interrupt
                if (stop_q && i_ext_int) begin
                    tmr_start = 1'b1;
                    state_d   = S_RECOVER;
                end else if (wait_q && i_int_req) begin
                    clk_en_d   = 1'b1;
                    wait_d     = 1'b0;
                    mem_d.addr = pc_q;
                    state_d    = S_FETCH;
                end
            end
            S_RECOVER: begin
                if (tmr_done) begin
                    clk_en_d   = 1'b1;
                    stop_d     = 1'b0;
                    mem_d.addr = pc_q;
                    state_d    = S_FETCH;
                end
            end
            default: begin
                state_d = S_FETCH;
                step_d  = 3'h0;
            end
        endcase
        // End of an instruction: a break seen now starts without another fetch
        if (done) begin
            if (i_brk_req && !brk_q) begin
                brk_d   = 1'b1;
                ir_d    = OP_SOFT_TRAP_OPCODE;
                vec_d   = i_monitor_mode ? VEC_TRAP_MONITOR : VEC_TRAP_NORMAL;
                ret_pc  = done_pc;
                go_push = 1'b1;
            end else begin
                pc_d       = done_pc;
                mem_d.addr = done_pc;
                state_d    = S_FETCH;
            end
        end
        // First stacked byte is written in the cycle after entry; it uses the
        // updated pointer, since an ending stack pointer sum may have moved it
        if (go_push) begin
            pc_d        = ret_pc;
            mem_d.addr  = sp_d;
            mem_d.wdata = ret_pc[7:0];
            mem_d.we    = 1'b1;
            step_d      = 3'h0;
            state_d     = S_PUSH;
        end
    end

    // Registers only; reset sets the mask and fetches the reset vector
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q  <= S_VEC;
            step_q   <= 3'h0;
            pc_q     <= WORD_ZERO;
            sp_q     <= SP_RESET;
            hx_q     <= WORD_ZERO;
            acc_q    <= BYTE_ZERO;
            ccr_q    <= ccr_t'(CCR_RESET);
            ir_q     <= BYTE_ZERO;
            opnd_q   <= BYTE_ZERO;
            vec_q    <= VEC_RESET;
            mem_q    <= '{addr: VEC_RESET, wdata: BYTE_ZERO, we: 1'b0};
            clk_en_q <= 1'b1;
            ack_q    <= 1'b0;
            brk_q    <= 1'b0;
            wait_q   <= 1'b0;
            stop_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            step_q   <= step_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            hx_q     <= hx_d;
            acc_q    <= acc_d;
            ccr_q    <= ccr_d;
            ir_q     <= ir_d;
            opnd_q   <= opnd_d;
            vec_q    <= vec_d;
            mem_q    <= mem_d;
            clk_en_q <= clk_en_d;
            ack_q    <= ack_d;
            brk_q    <= brk_d;
            wait_q   <= wait_d;
            stop_q   <= stop_d;
        end
    end

    // Outputs straight from registers
    assign o_mem          = mem_q;
    assign o_cpu_clk_en   = clk_en_q;
    assign o_int_ack      = ack_q;
    assign o_break_active = brk_q;
    assign o_wait_mode    = wait_q;
    assign o_stop_mode    = stop_q;
    assign o_ccr          = ccr_q;
    assign o_pc           = pc_q;
    assign o_sp           = sp_q;
    assign o_hx           = hx_q;
    assign o_acc          = acc_q;

endmodule // core_ctrl

// ==== core_pkg.sv ====
// Constants, types and helper functions for the standby, break and opcode subset core
package core_pkg;

    // Opcodes handled by this core
    localparam logic [7:0] OP_STACK_PTR_SIGNED_IMM_SUM = 8'hA7;
    localparam logic [7:0] OP_INDEX_REG_SIGNED_IMM_SUM = 8'hAF;
    localparam logic [7:0] OP_SUM_WITH_CARRY_IMM       = 8'hA9;
    localparam logic [7:0] OP_SUM_IMM                  = 8'hAB;
    localparam logic [7:0] OP_CONJUNCTION_IMM          = 8'hA4;
    localparam logic [7:0] OP_BRANCH_ON_NO_CARRY       = 8'h24;
    localparam logic [7:0] OP_BRANCH_ON_CARRY          = 8'h25;
    localparam logic [7:0] OP_BRANCH_NIBBLE_CARRY_CLR  = 8'h28;
    localparam logic [7:0] OP_BRANCH_NIBBLE_CARRY_SET  = 8'h29;
    localparam logic [7:0] OP_BRANCH_SIGNED_GE         = 8'h90;
    localparam logic [7:0] OP_BRANCH_SIGNED_GT         = 8'h92;
    localparam logic [7:0] OP_SOFT_TRAP_OPCODE         = 8'h83;
    localparam logic [7:0] OP_RETURN_FROM_TRAP         = 8'h80;
    localparam logic [7:0] OP_IDLE_STANDBY             = 8'h8F;
    localparam logic [7:0] OP_HALT_STANDBY             = 8'h8E;

    // Vectors and reset values
    localparam logic [15:0] VEC_RESET         = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP_NORMAL   = 16'hFFFC;
    localparam logic [15:0] VEC_TRAP_MONITOR  = 16'hFEFC;
    localparam logic [15:0] SP_RESET          = 16'h00FF;
    localparam logic [15:0] WORD_ZERO         = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO         = 8'h00;
    localparam logic [7:0]  CCR_RESET         = 8'h68;
    localparam logic [7:0]  CCR_FIXED_ONES    = 8'h60;

    // Stacking sequence: five bytes, step index 0..4
    localparam logic [2:0]  STACK_LAST_STEP   = 3'h4;

    // Oscillator stabilization delay after halt standby, in bus clock cycles
    localparam int          OSC_STAB_CYCLES   = 4096;
    localparam int          STAB_CNT_W        = 13;
    localparam logic [STAB_CNT_W-1:0] STAB_LAST = STAB_CNT_W'(OSC_STAB_CYCLES - 1);

    // Condition code register, bit 7 down to bit 0
    typedef struct packed {
        logic v;
        logic one6;
        logic one5;
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } ccr_t;

    // Memory bus request toward the system
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } mem_req_t;

    typedef enum logic [2:0] {
        S_VEC     = 3'b000,
        S_FETCH   = 3'b001,
        S_EXEC    = 3'b010,
        S_PUSH    = 3'b011,
        S_PULL    = 3'b100,
        S_STANDBY = 3'b101,
        S_RECOVER = 3'b110
    } core_state_t;

    // Two's-complement widening of an offset or immediate byte
    function automatic logic [15:0] sext8(input logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // Condition test for the relative branches
    function automatic logic branch_taken(input logic [7:0] op, input ccr_t f);
        case (op)
            OP_BRANCH_ON_NO_CARRY:      branch_taken = ~f.c;
            OP_BRANCH_ON_CARRY:         branch_taken = f.c;
            OP_BRANCH_NIBBLE_CARRY_CLR: branch_taken = ~f.h;
            OP_BRANCH_NIBBLE_CARRY_SET: branch_taken = f.h;
            OP_BRANCH_SIGNED_GE:        branch_taken = ~(f.n ^ f.v);
            OP_BRANCH_SIGNED_GT:        branch_taken = ~(f.z | (f.n ^ f.v));
            default:                    branch_taken = 1'b0;
        endcase
    endfunction

endpackage

// ==== stab_timer.sv ====
// Oscillator stabilization delay counter used when leaving halt standby
`timescale 1ns/10ps
module stab_timer
    import core_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_start,
    output logic      o_done
);

    logic [STAB_CNT_W-1:0] cnt_q;
    logic [STAB_CNT_W-1:0] cnt_d;
    logic                  run_q;
    logic                  run_d;
    logic                  done_q;
    logic                  done_d;

    // Count from start to the last cycle, then pulse done once
    always_comb begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (i_start) begin
            cnt_d = '0;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == STAB_LAST) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;

endmodule // stab_timer

// ==== core_ctrl_sva.sv ====
// Port assertions for the core control block
`timescale 1ns/10ps
module core_ctrl_sva
    import core_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_monitor_mode,
    input  wire logic        i_ext_int,
    input  wire mem_req_t    o_mem,
    input  wire logic        o_cpu_clk_en,
    input  wire logic        o_int_ack,
    input  wire logic        o_break_active,
    input  wire logic        o_wait_mode,
    input  wire logic        o_stop_mode,
    input  wire ccr_t        o_ccr,
    input  wire logic [15:0] o_sp
);
    logic [STAB_CNT_W-1:0] halt_q;
    logic [STAB_CNT_W-1:0] halt_d;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Five stacked bytes of an interrupt or break entry
    sequence stack_seq;
        o_mem.we [*5];
    endsequence

    // Cycles since the external wake in halt; saturates so it never wraps
    always_comb begin
        halt_d = '0;
        if (o_stop_mode && (i_ext_int || halt_q != '0)) begin
            halt_d = (&halt_q) ? halt_q : halt_q + 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            halt_q <= '0;
        end else begin
            halt_q <= halt_d;
        end
    end

    a_reset_mask_set: assert property ($fell(i_sys_rst) |-> o_ccr == CCR_RESET)
        else $error("mask not set after reset");
    a_idle_entry: assert property ($rose(o_wait_mode) |-> !o_ccr.i && !o_cpu_clk_en)
        else $error("idle entry left mask or clock on");
    a_halt_entry: assert property ($rose(o_stop_mode) |-> !o_ccr.i && !o_cpu_clk_en)
        else $error("halt entry left mask or clock on");
    a_standby_clock: assert property ((o_wait_mode || o_stop_mode) |-> !o_cpu_clk_en)
        else $error("clock runs in standby");
    a_halt_stab: assert property ($fell(o_stop_mode) |-> o_cpu_clk_en && halt_q >= STAB_LAST)
        else $error("clock resumed before stabilization");
    a_int_masked: assert property ($rose(o_int_ack) |-> !$past(o_ccr.i))
        else $error("interrupt taken while masked");
    a_mask_after_stack: assert property ($rose(o_int_ack) |-> stack_seq ##[1:2] o_ccr.i)
        else $error("mask not set after stacking");
    a_stack_depth: assert property ($rose(o_int_ack) |-> ##5 o_sp == $past(o_sp, 5) - 16'h0005)
        else $error("stack pointer not moved by five bytes");
    a_break_vector: assert property ($rose(o_break_active) |-> stack_seq ##1
        o_mem.addr == (i_monitor_mode ? VEC_TRAP_MONITOR : VEC_TRAP_NORMAL))
        else $error("break vector address wrong");
endmodule // core_ctrl_sva

bind core_ctrl core_ctrl_sva chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_monitor_mode(i_monitor_mode),
    .i_ext_int(i_ext_int),
    .o_mem(o_mem), .o_cpu_clk_en(o_cpu_clk_en), .o_int_ack(o_int_ack), .o_break_active(o_break_active),
    .o_wait_mode(o_wait_mode), .o_stop_mode(o_stop_mode), .o_ccr(o_ccr), .o_sp(o_sp));

// ==== mem_model.sv ====
// Memory model answering the core's bus with no wait states
`timescale 1ns/10ps
module mem_model
    import core_pkg::*;
(
    input  wire logic     i_clk,
    input  wire mem_req_t i_mem,
    output logic [7:0]    o_rdata
);
    logic [7:0] mem_q [0:65535];

    // Asynchronous read, the core wants data in the access cycle
    assign o_rdata = mem_q[i_mem.addr];

    // Stacked bytes land at the edge closing the write cycle
    always @(posedge i_clk) begin
        if (i_mem.we) begin
            mem_q[i_mem.addr] <= i_mem.wdata;
        end
    end
endmodule // mem_model

// ==== core_ctrl_tb.sv ====
// Self-checking bench for the core control block
`timescale 1ns/10ps
module core_ctrl_tb;
    import core_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        int_req = 1'b0;
    logic        ext_int = 1'b0;
    logic        brk_req = 1'b0;
    logic        mon = 1'b0;
    logic [7:0]  rdata;
    mem_req_t    mem;
    logic        clk_en, int_ack, brk_act, wait_m, stop_m;
    ccr_t        ccr;
    logic [15:0] pc, sp, hx;
    logic [7:0]  acc;
    int          failures = 0;
    int          checks_done = 0;

    always #2.5 i_clk = ~i_clk;

    core_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mem_rdata(rdata), .i_int_req(int_req),
        .i_ext_int(ext_int), .i_int_vector(16'hFFF0), .i_brk_req(brk_req), .i_monitor_mode(mon),
        .o_mem(mem), .o_cpu_clk_en(clk_en), .o_int_ack(int_ack), .o_break_active(brk_act),
        .o_wait_mode(wait_m), .o_stop_mode(stop_m), .o_ccr(ccr), .o_pc(pc), .o_sp(sp), .o_hx(hx), .o_acc(acc));
    mem_model mem_u (.i_clk(i_clk), .i_mem(mem), .o_rdata(rdata));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for a read access at one address; a wrong path halts
    task automatic wait_addr(input logic [15:0] a);
        for (int n = 0; n < 6000; n++) begin
            @(negedge i_clk);
            if (mem.addr === a && mem.we === 1'b0) return;
        end
        check("wait timeout", 16'h0001, 16'h0000);
        end_sim();
    endtask

    task automatic load(input logic [15:0] a, input logic [63:0] d);
        for (int k = 0; k < 8; k++) mem_u.mem_q[a + 16'(k)] = d[63-8*k -: 8];
    endtask

    initial begin
        int n;
        logic [15:0] tgt [8];
        tgt = '{16'h010C, 16'h010E, 16'h0114, 16'h0116, 16'h011A, 16'h011E, 16'h0122, 16'h0130};
        // Unused memory holds halt, so any wrong branch stalls the run
        for (int k = 0; k < 65536; k++) mem_u.mem_q[k] = OP_HALT_STANDBY;
        load(16'h0100, 64'hA7FE_AF05_A90F_AB01);
        load(16'h0108, 64'h2402_8E8E_2510_2904);
        load(16'h0114, 64'h2810_9002_8E8E_9202);
        load(16'h011C, 64'h8E8E_A400_9210_900C);
        load(16'h0124, 64'h8F8E_8E8E_8E8E_8E8E);
        load(16'h0130, 64'h29F2_8E8E_8E8E_8E8E);
        load(16'h0200, 64'h8E83_8E8E_8E8E_8E8E);
        load(16'h0300, 64'h808E_8E8E_8E8E_8E8E);
        load(16'h0400, 64'h8F8E_8E8E_8E8E_8E8E);
        load(16'hFEFC, 64'h0300_8E8E_8E8E_8E8E);
        load(16'hFFF0, 64'h0200_8E8E_8E8E_8E8E);
        load(16'hFFF8, 64'h8E8E_8E8E_0400_0100);
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        check("ccr reset", ccr, CCR_RESET);
        wait_addr(16'h0104);
        check("sp", sp, 16'h00FD);
        check("hx", hx, 16'h0005);
        check("ccr kept", ccr, CCR_RESET);
        wait_addr(16'h0108);
        check("acc", acc, 16'h0010);
        check("ccr sum", ccr, 16'h0078);
        foreach (tgt[k]) wait_addr(tgt[k]);
        wait_addr(16'h0124);
        check("pc", pc, 16'h0124);
        check("ccr and", ccr, 16'h007A);
        // Idle standby, woken by a maskable request
        repeat (3) @(negedge i_clk);
        check("idle", {wait_m, ccr.i, clk_en}, 16'h0004);
        @(posedge i_clk) int_req <= 1'b1;
        wait_addr(16'h0200);
        check("stacked mask", mem_u.mem_q[16'h00F9][3], 16'h0000);
        check("stacked pcl", mem_u.mem_q[16'h00FD], 16'h0025);
        check("mask set", ccr.i, 16'h0001);
        // Request still high at this fetch: the set mask must hold it off
        @(posedge i_clk) int_req <= 1'b0;
        // Halt standby: a maskable request must not wake it
        repeat (3) @(negedge i_clk);
        @(posedge i_clk) int_req <= 1'b1;
        repeat (10) @(negedge i_clk);
        check("halt", {stop_m, ccr.i, clk_en}, 16'h0004);
        @(posedge i_clk) int_req <= 1'b0;
        mon <= 1'b1;
        brk_req <= 1'b1;
        ext_int <= 1'b1;
        for (n = 0; n < 6000 && clk_en !== 1'b1; n++) @(negedge i_clk);
        check("stab", {n >= OSC_STAB_CYCLES, clk_en}, 16'h0003);
        check("mask after halt", ccr.i, 16'h0000);
        @(posedge i_clk) ext_int <= 1'b0;
        // Break in monitor mode, then return with the request withdrawn
        wait_addr(16'h0300);
        check("break", {brk_act, ccr.i}, 16'h0003);
        @(posedge i_clk) brk_req <= 1'b0;
        mon <= 1'b0;
        wait_addr(16'h0201);
        check("break end", brk_act, 16'h0000);
        wait_addr(16'h0400);
        repeat (3) @(negedge i_clk);
        check("idle again", wait_m, 16'h0001);
        // Reset ends standby and leaves the mask set
        @(posedge i_clk) i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        check("reset wake", {wait_m, ccr}, {8'h00, CCR_RESET});
        // Break raised during a stack pointer sum starts at its last cycle
        wait_addr(16'h0100);
        @(posedge i_clk) brk_req <= 1'b1;
        wait_addr(16'h0400);
        check("early break", {brk_act, mem_u.mem_q[16'h00FD]}, 16'h0102);
        check("break sp", sp, 16'h00F8);
        end_sim();
    end
endmodule // core_ctrl_tb
